// >>> core/hbca_top.v
// bridge-side byte command interpreter: tx/rx buffers, status, responses
// assumes host byte accesses synchronous to mclk_i; cal memory loaded
// through the cal write port before use

`include "hbca_defines.vh"

// ============================================================
// Notes on behaviour
// - every non-cal query answers eight bytes, MSB first
// - command bytes accepted at offset 0x1000
// - one ack byte after full register write
// - query leaves eight bytes for host
// - cal floats stored little-endian, four bytes
// - cal read returns eight bytes from address
// - 22 IF cal frequencies at 0x338
// - two 30-entry attenuator tables 0x5CC, 0x644
// - 17 bypass freqs 0x7E8, gains 0x82C
// - ack byte has bit 1 set
// - eight data bits per character, no flow
module hbca_top #(
  parameter CAL_AW = 12,
  parameter FDEPTH = 32,
  parameter FAW    = 5
) (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire [15:0] bus_addr_i,
  input  wire [7:0]  bus_wdata_i,
  input  wire        bus_wr_i,
  input  wire        bus_rd_i,
  output wire [7:0]  bus_rdata_o,
  input  wire        bridge_en_i,
  input  wire [7:0]  cmd_len_i,
  input  wire [CAL_AW-1:0] cal_waddr_i,
  input  wire [7:0]  cal_wdata_i,
  input  wire        cal_we_i,
  input  wire [63:0] query_data_i,
  output reg  [7:0]  exec_addr_o,
  output reg  [63:0] exec_data_o,
  output reg         exec_strobe_o,
  output wire        busy_o
);

  // ============================================================
  // state
  localparam S_ADDR = 2'b00;
  localparam S_DATA = 2'b01;
  localparam S_RESP = 2'b10;

  reg  [1:0]  st_q;
  reg  [7:0]  cmd_q;
  reg  [7:0]  need_q;
  reg  [63:0] sh_q;
  reg  [3:0]  rcnt_q;
  reg         isq_q;
  reg         iscal_q;
  reg  [7:0]  rdata_q;
  reg  [7:0]  cal_mem [0:`HBCA_CAL_DEPTH-1];
  reg  [7:0]  rbyte;

  wire [7:0]  rx_data;
  wire        rx_valid;
  wire        rx_ready;
  wire        rx_pop;
  wire        rx_push;
  wire        tx_wr;
  wire        tx_ready;
  wire [CAL_AW-1:0] cal_ptr;
  wire        hit_txbuf;
  wire        hit_rxbuf;
  wire        hit_rxstat;
  wire        hit_txstat;
  wire        is_query;
  wire        is_cal;
  wire        cmd_done;
  wire        q_load;
  wire        resp_last;
  reg  [1:0]  st_d;
  reg  [7:0]  rdata_d;
  wire [7:0]  q_lane [0:7];
  genvar      g;

  // ============================================================
  // bus decode
  // only these offsets matter; other bridge registers read as zero
  assign hit_txbuf  = (bus_addr_i == `HBCA_OFS_TXBUF);
  assign hit_rxbuf  = (bus_addr_i == `HBCA_OFS_RXBUF);
  assign hit_rxstat = (bus_addr_i == `HBCA_OFS_RXSTAT);
  assign hit_txstat = (bus_addr_i == `HBCA_OFS_TXSTAT);
  // addresses from the query base up answer eight bytes
  assign is_query   = (bus_wdata_i >= `HBCA_QUERY_BASE);
  assign is_cal     = (bus_wdata_i == `HBCA_CAL_CMD);

  assign tx_wr = ce_i && bus_wr_i && bridge_en_i && hit_txbuf && tx_ready;

  // tx ready in S_ADDR and S_DATA; blocks only while S_RESP pushes the response
  assign tx_ready = (st_q != S_RESP);

  assign rx_pop = bus_rd_i && bridge_en_i && hit_rxbuf && rx_valid;

  // ============================================================
  // read data
  always @* begin
    rdata_d = 8'h00;
    if (hit_rxbuf) begin
      rdata_d = rx_valid ? rx_data : 8'h00;
    end else if (hit_rxstat) begin
      rdata_d = {7'h00, rx_valid};
    end else if (hit_txstat) begin
      rdata_d = {tx_ready, 7'h00};
    end
  end

  // registered so the value stands until the next read
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i && bus_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign busy_o      = (st_q != S_ADDR);

  // ============================================================
  // calibration memory
  // bytes kept as stored, little-endian floats
  always @(posedge mclk_i) begin
    if (ce_i && cal_we_i) begin
      cal_mem[cal_waddr_i] <= cal_wdata_i;
    end
  end
  // IF freq table lives at fixed offset
  // attenuator tables in same flat store
  // bypass tables in same flat store
  assign cal_ptr = sh_q[CAL_AW-1:0] + {{(CAL_AW-4){1'b0}}, rcnt_q};

  // ============================================================
  // response byte select
  // query word split into lanes, lane 7 leaves first
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_lane
      assign q_lane[g] = sh_q[8*g+7:8*g];
    end
  endgenerate

  // cal bytes come straight from the store, lowest address first
  always @* begin
    rbyte = `HBCA_ACK_BYTE;
    if (isq_q && iscal_q) begin
      rbyte = cal_mem[cal_ptr];
    end else if (isq_q) begin
      rbyte = q_lane[7];
    end
  end

  assign rx_push = (st_q == S_RESP) && rx_ready && ce_i;

  // query word is loaded in the strobe cycle, so nothing is pushed then
  assign q_load    = exec_strobe_o && isq_q && !iscal_q;
  assign resp_last = !isq_q || (rcnt_q == `HBCA_RESP_BYTES - 4'h1);

  // ============================================================
  // command sequencer, next state
  always @* begin
    st_d = st_q;
    case (st_q)
      S_ADDR: begin
        // at least one data byte expected
        if (tx_wr && (cmd_len_i != 8'h00)) begin
          st_d = S_DATA;
        end
      end

      S_DATA: begin
        if (cmd_done) begin
          st_d = S_RESP;
        end
      end

      S_RESP: begin
        if (!q_load && rx_push && resp_last) begin
          st_d = S_ADDR;
        end
      end

      default: begin
        st_d = S_ADDR;
      end
    endcase
  end

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_ADDR;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // command capture
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q   <= 8'h00;
      sh_q    <= 64'h0;
      isq_q   <= 1'b0;
      iscal_q <= 1'b0;
    end else if (ce_i) begin
      if ((st_q == S_ADDR) && tx_wr) begin
        cmd_q   <= bus_wdata_i;
        sh_q    <= 64'h0;
        isq_q   <= is_query;
        iscal_q <= is_cal;
      end else if ((st_q == S_DATA) && tx_wr) begin
        sh_q <= {sh_q[55:0], bus_wdata_i};
      end else if ((st_q == S_RESP) && q_load) begin
        // load query word once execution returns it
        sh_q <= query_data_i;
      end else if ((st_q == S_RESP) && rx_push) begin
        if (isq_q && !iscal_q) begin
          sh_q <= {sh_q[55:0], 8'h00};
        end
      end
    end
  end

  // data bytes still owed for the current command
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      need_q <= 8'h00;
    end else if (ce_i && tx_wr) begin
      if (st_q == S_ADDR) begin
        need_q <= cmd_len_i;
      end else if (st_q == S_DATA) begin
        need_q <= need_q - 8'h01;
      end
    end
  end

  // response byte counter; restarts with every command
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rcnt_q <= 4'h0;
    end else if (ce_i) begin
      if (cmd_done) begin
        rcnt_q <= 4'h0;
      end else if ((st_q == S_RESP) && !q_load && rx_push) begin
        rcnt_q <= rcnt_q + 4'h1;
      end
    end
  end

  // ============================================================
  // exec address and data stand until the next full command
  // strobe one cycle after the last data byte is accepted
  assign cmd_done = (st_q == S_DATA) && tx_wr && (need_q == 8'h01);

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      exec_addr_o   <= 8'h00;
      exec_data_o   <= 64'h0;
      exec_strobe_o <= 1'b0;
    end else if (ce_i) begin
      exec_strobe_o <= cmd_done;
      if (cmd_done) begin
        exec_addr_o <= cmd_q;
        exec_data_o <= {sh_q[55:0], bus_wdata_i};
      end
    end
  end

  // ============================================================
  // receive fifo; host read pops it
  // a full fifo stalls the response pushes rather than dropping bytes
  hbca_fifo #(
    .W  (8),
    .D  (FDEPTH),
    .AW (FAW)
  ) u_rxfifo (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (rbyte),
    .in_valid_i  (rx_push && !q_load),
    .in_ready_o  (rx_ready),
    .out_data_o  (rx_data),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_pop)
  );
endmodule

// >>> core/hbca_defines.vh
// constants for the host byte command block
// assumes inclusion by bare name from core/ design files
`ifndef HBCA_DEFINES_VH
`define HBCA_DEFINES_VH
`define HBCA_OFS_RXBUF    16'h0000
`define HBCA_OFS_RXSTAT   16'h0005
`define HBCA_OFS_TXBUF    16'h1000
`define HBCA_OFS_TXSTAT   16'h1005
`define HBCA_RXSTAT_VALID 0
`define HBCA_TXSTAT_READY 7
`define HBCA_ACK_OK_BIT   1
`define HBCA_ACK_BYTE     8'h02
`define HBCA_RESP_BYTES   4'h8
`define HBCA_CAL_CMD      8'h40
`define HBCA_QUERY_BASE   8'h30
`define HBCA_CAL_FREQ     12'h338
`define HBCA_CAL_FREQ_N   22
`define HBCA_CAL_AT1      12'h5CC
`define HBCA_CAL_AT2      12'h644
`define HBCA_CAL_AT_N     30
`define HBCA_CAL_BPF      12'h7E8
`define HBCA_CAL_BPG      12'h82C
`define HBCA_CAL_BP_N     17
`define HBCA_CAL_DEPTH    4096
`endif

// >>> core/hbca_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock, async active-high reset, clock enable
module hbca_fifo #(
  parameter W  = 8,
  parameter D  = 32,
  parameter AW = 5
) (
  input  wire          mclk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  input  wire [W-1:0]  in_data_i,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  output wire [W-1:0]  out_data_o,
  output wire          out_valid_o,
  input  wire          out_ready_i
);
  reg [W-1:0]  mem [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0]   cnt_q;
  wire         wr;
  wire         rd;
  assign in_ready_o  = (cnt_q != D);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o  = mem[rp_q];
  assign wr = ce_i && in_valid_i && in_ready_o;
  assign rd = ce_i && out_ready_i && out_valid_o;
  always @(posedge mclk_i) begin
    if (wr) begin
      mem[wp_q] <= in_data_i;
    end
  end
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        wp_q <= (wp_q == D-1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (rd) begin
        rp_q <= (rp_q == D-1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (wr && !rd) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd && !wr) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// >>> sim/hbca_checker.sv
// assertions on the hbca_top ports
// assumes the bench holds ce_i high
module hbca_checker (
  input wire        mclk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire [15:0] bus_addr_i,
  input wire [7:0]  bus_wdata_i,
  input wire        bus_wr_i,
  input wire        bus_rd_i,
  input wire [7:0]  bus_rdata_o,
  input wire        bridge_en_i,
  input wire [7:0]  cmd_len_i,
  input wire [7:0]  exec_addr_o,
  input wire [63:0] exec_data_o,
  input wire        exec_strobe_o,
  input wire        busy_o
);
  // ====================
  // properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_txw;
    bus_wr_i && ce_i && bridge_en_i && bus_addr_i == 16'h1000;
  endsequence
  sequence s_new_cmd;
    s_txw ##0 (!busy_o && cmd_len_i != 8'h00);
  endsequence
  property p_pulse;
    exec_strobe_o |=> !exec_strobe_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_cause;
    exec_strobe_o |-> $past(bus_wr_i && bridge_en_i && bus_addr_i == 16'h1000);
  endproperty
  a_cause: assert property (p_cause) else $error("stray strobe");
  property p_low;
    exec_strobe_o |-> exec_data_o[7:0] == $past(bus_wdata_i);
  endproperty
  a_low: assert property (p_low) else $error("last byte");
  property p_busy;
    s_new_cmd |=> busy_o;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy");
  property p_hold;
    !exec_strobe_o |-> $stable(exec_data_o) && $stable(exec_addr_o);
  endproperty
  a_hold: assert property (p_hold) else $error("exec moved");
  property p_rdhold;
    !bus_rd_i |=> $stable(bus_rdata_o);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("rdata moved");
  property p_rdy;
    bus_rd_i && bus_addr_i == 16'h1005 && bridge_en_i && !busy_o
      |=> bus_rdata_o[7];
  endproperty
  a_rdy: assert property (p_rdy) else $error("tx not ready");
  property p_done;
    exec_strobe_o |-> ##[1:40] !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("stuck busy");
endmodule
bind hbca_top hbca_checker u_chk (.*);

// >>> sim/hbca_host.sv
// host driver model: bus cycles, status polls, bridge setup
// assumes the bench calls its tasks; drives at falling edge
module hbca_host (
  input  wire         mclk_i,
  input  wire  [7:0]  rdata_i,
  output logic [15:0] addr_o,
  output logic [7:0]  wdata_o,
  output logic        wr_o,
  output logic        rd_o,
  output logic        en_o,
  output logic [7:0]  len_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'h0;
    rd_o = 1'h0;
    en_o = 1'h0;
    len_o = 8'h00;
  end
  // ====================
  // bus cycles
  task automatic wr(input [15:0] a, input [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'h1;
    @(negedge mclk_i);
    wr_o = 1'h0;
    wdata_o = ~d;
  endtask
  task automatic rd(input [15:0] a, output [7:0] d);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'h1;
    @(negedge mclk_i);
    rd_o = 1'h0;
    d = rdata_i;
  endtask
  task automatic poll(input [15:0] a, input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 100 && s[b] !== 1'h1; n++) rd(a, s);
    if (s[b] !== 1'h1) test_host_byte_command_access.wrap_up(1'h1);
  endtask
  task automatic init;
    logic [23:0] t [10] = '{24'h10CC00, 24'h100480, 24'h10C204,
      24'h10C100, 24'h10C301, 24'h100380, 24'h100010, 24'h100100,
      24'h100303, 24'h100207};
    foreach (t[i]) wr(t[i][23:8], t[i][7:0]);
    en_o = 1'h1;
  endtask
  task automatic send(input [7:0] ra, input [7:0] n, input [63:0] d);
    poll(16'h1005, 7);
    len_o = n;
    wr(16'h1000, ra);
    for (int i = n - 1; i >= 0; i--) wr(16'h1000, d[8*i +: 8]);
  endtask
  task automatic get(output [7:0] d);
    poll(16'h0005, 0);
    rd(16'h0000, d);
  endtask
endmodule

// >>> sim/test_host_byte_command_access.sv
// self-checking bench for the byte command interpreter
// assumes hbca_host as host; cal memory loaded through its port
module test_host_byte_command_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, cal_we = 1'h0;
  logic [11:0] cal_a = 12'h000;
  logic [7:0]  cal_d = 8'h00;
  logic [63:0] qdata = 64'h0;
  wire [15:0] addr;
  wire [7:0]  wdata, rdata, len, xaddr;
  wire        wr, rd, en, strobe, busy;
  wire [63:0] xdata;
  int failures = 0, cmp_count = 0;
  hbca_host host (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .en_o(en), .len_o(len));
  hbca_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .bridge_en_i(en), .cmd_len_i(len),
    .cal_waddr_i(cal_a), .cal_wdata_i(cal_d), .cal_we_i(cal_we),
    .query_data_i(qdata), .exec_addr_o(xaddr), .exec_data_o(xdata),
    .exec_strobe_o(strobe), .busy_o(busy));
  initial forever #25 mclk_i = ~mclk_i;
  // ====================
  // checking and closing
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up(input bit to);
    if (to) failures++;
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ====================
  // scenarios
  task automatic t_cfg;
    logic [7:0] b;
    host.send(8'h05, 8'h02, 64'h0012);
    host.get(b);
    chk(b, 8'h02);
    chk(xaddr, 8'h05);
    chk(xdata, 64'h0012);
    chk(busy, 1'h0);
    chk(strobe, 1'h0);
    host.rd(16'h0005, b);
    chk(b[0], 1'h0);
    host.rd(16'h0000, b);
    chk(b, 8'h00);
  endtask
  task automatic t_query;
    logic [7:0] b;
    qdata = 64'h0123456789ABCDEF;
    host.send(8'h31, 8'h01, 64'h00);
    for (int i = 7; i >= 0; i--) begin
      host.get(b);
      chk(b, qdata[8*i +: 8]);
    end
    host.rd(16'h0005, b);
    chk(b[0], 1'h0);
  endtask
  // two floats, 25.0 and 50.0, stored low byte first, each byte XORed with the table index k (plain floats only at 0x338)
  task automatic t_cal;
    logic [11:0] base [5] = '{12'h338, 12'h5CC, 12'h644, 12'h7E8, 12'h82C};
    logic [63:0] pat = 64'h0000C841_00004842;
    logic [7:0] b;
    foreach (base[k]) begin
      for (int i = 0; i < 8; i++) begin
        @(negedge mclk_i);
        cal_a = base[k] + 12'(i);
        cal_d = pat[63-8*i -: 8] ^ 8'(k);
        cal_we = 1'h1;
      end
      @(negedge mclk_i);
      cal_we = 1'h0;
      host.send(8'h40, 8'h02, {52'h0, base[k]});
      for (int i = 0; i < 8; i++) begin
        host.get(b);
        chk(b, pat[63-8*i -: 8] ^ 8'(k));
      end
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'h0;
    host.init();
    t_cfg();
    t_query();
    t_cal();
    wrap_up(1'h0);
  end
endmodule
